// *** fwsr_pkg.sv ***
// Shared constants, states and state records of the flash erase status host controller
package fwsr_pkg;

	// ==========================================================
	// Clock and flash bus cycle timing
	localparam int CLK_NS    = 10;
	localparam int T_RD_NS   = 100;
	localparam int T_WP_NS   = 50;
	localparam int T_REC_NS  = 30;
	localparam logic [3:0] RD_CYC  = 4'((T_RD_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] WP_CYC  = 4'((T_WP_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [3:0] REC_CYC = 4'((T_REC_NS + CLK_NS - 1) / CLK_NS);

	// ==========================================================
	// Flash command cycles
	localparam logic [20:0] UNLK_A1 = 21'h000555;
	localparam logic [20:0] UNLK_A2 = 21'h0002AA;
	localparam logic [7:0]  UNLK_D1 = 8'hAA;
	localparam logic [7:0]  UNLK_D2 = 8'h55;
	localparam logic [7:0]  ERS_SETUP = 8'h80;
	localparam logic [7:0]  SEC_ERASE = 8'h30;
	localparam logic [7:0]  FL_RESET  = 8'hF0;
	localparam logic [2:0]  ERS_LAST  = 3'h5;

	// ==========================================================
	// Status byte bit positions
	localparam int DATA_POLL_POS  = 7;
	localparam int TOGGLE_ONE_POS = 6;
	localparam int FAIL_POS       = 5;
	localparam int TIMER_POS      = 3;

	// ==========================================================
	// Register map (byte addresses) and fields
	localparam logic [7:0] REG_CTRL     = 8'h00;
	localparam logic [7:0] REG_SECTOR   = 8'h04;
	localparam logic [7:0] REG_STATUS   = 8'h08;
	localparam logic [7:0] REG_IRQ_STAT = 8'h0C;
	localparam logic [7:0] REG_IRQ_MASK = 8'h10;
	localparam logic [1:0] CMD_ERASE = 2'h1;
	localparam logic [1:0] CMD_ADD   = 2'h2;
	localparam logic [1:0] CMD_POLL  = 2'h3;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_REJ  = 1;
	localparam int IRQ_FAIL = 2;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// State types
	typedef enum logic [1:0] {C_IDLE, C_ACT, C_REC} fwsr_cyc_e;

	typedef enum logic [3:0] {
		S_IDLE, S_ER_W, S_ACC_R1, S_ACC_R2, S_TMR_R, S_ADD_PRE, S_ADD_W,
		S_ADD_POST, S_POLL_R1, S_POLL_R2, S_POLL_R3, S_RST_W, S_FIN
	} fwsr_st_e;

	typedef struct packed {
		fwsr_cyc_e   st;
		logic [3:0]  cnt;
		logic        we;
		logic [20:0] addr;
		logic [7:0]  wd;
		logic [7:0]  rd;
		logic        done;
	} fwsr_cyc_s;

	typedef struct packed {
		fwsr_st_e    st;
		logic [2:0]  step;
		logic        pend;
		logic [7:0]  first;
		logic [7:0]  last;
		logic [20:0] sector;
		logic        accepted;
		logic        timer_hi;
		logic        rejected;
		logic        fail;
		logic        running;
		logic [2:0]  irq_stat;
		logic [2:0]  irq_mask;
		logic        go;
		logic        we;
		logic [20:0] addr;
		logic [7:0]  wd;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
	} fwsr_main_s;

endpackage

// *** fwsr_cyc.sv ***
// One asynchronous flash bus cycle (read or write) paced from the system clock
`timescale 1ns/1ps
module fwsr_cyc import fwsr_pkg::*; (
	input  wire logic        clk,     // System clock
	input  wire logic        rst,     // Sync reset, high
	input  wire logic        go,      // Start one cycle
	input  wire logic        we,      // 1 write, 0 read
	input  wire logic [20:0] addr,    // Cycle address
	input  wire logic [7:0]  wdata,   // Write byte
	output logic             done,    // Cycle finished pulse
	output logic [7:0]       rdata,   // Byte sampled on read
	output logic [20:0]      fl_addr, // Flash address pins
	output logic [7:0]       dq_o,    // Data bus drive value
	output logic             dq_oe,   // Data bus drive enable
	input  wire logic [7:0]  dq_i,    // Data bus level
	output logic             ce_n,    // Chip enable, low
	output logic             oe_n,    // Output enable, low
	output logic             we_n     // Write enable, low
);
	fwsr_cyc_s s_r, s_nxt;

	// ==========================================================
	// Cycle sequencer
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		case (s_r.st)
			C_IDLE: begin
				if (go) begin
					s_nxt.st = C_ACT;
					s_nxt.cnt = we ? WP_CYC : RD_CYC;
					s_nxt.we = we;
					s_nxt.addr = addr;
					s_nxt.wd = wdata;
				end
			end
			C_ACT: begin
				if (s_r.cnt == 4'h1) begin
					s_nxt.st = C_REC;
					s_nxt.cnt = REC_CYC;
					// Sample at the end of the strobe, after access time
					if (!s_r.we) s_nxt.rd = dq_i;
				end else begin
					s_nxt.cnt = s_r.cnt - 4'h1;
				end
			end
			C_REC: begin
				if (s_r.cnt == 4'h1) begin
					s_nxt.st = C_IDLE;
					s_nxt.done = 1'b1;
				end else begin
					s_nxt.cnt = s_r.cnt - 4'h1;
				end
			end
			default: s_nxt.st = C_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) s_r <= '0;
		else s_r <= s_nxt;
	end

	assign done = s_r.done;
	assign rdata = s_r.rd;
	assign fl_addr = s_r.addr;
	assign dq_o = s_r.wd;
	// Data held through recovery so the device sees hold time after strobe
	assign dq_oe = s_r.we && (s_r.st != C_IDLE);
	assign ce_n = (s_r.st != C_ACT);
	assign oe_n = !((s_r.st == C_ACT) && !s_r.we);
	assign we_n = !((s_r.st == C_ACT) && s_r.we);

	// ==========================================================
	// Checks
	property p_read_strobe_len;
		@(posedge clk) disable iff (rst)
		$fell(oe_n) |-> !oe_n [*8] ##1 !oe_n ##1 !oe_n ##1 oe_n;
	endproperty
	a_read_strobe_len: assert property (p_read_strobe_len) else $error("read strobe length wrong");

	property p_bus_quiet;
		@(posedge clk) disable iff (rst)
		!(dq_oe && !oe_n);
	endproperty
	a_bus_quiet: assert property (p_bus_quiet) else $error("drive during read");
endmodule

// *** fwsr_top.sv ***
// Host controller: erase, add-sector and status polling of a parallel flash, AXI4-Lite control
`timescale 1ns/1ps
module fwsr_top import fwsr_pkg::*; (
	input  wire logic        CLK,              // 100 MHz clock
	input  wire logic        RST,              // Sync reset, high
	input  wire logic [7:0]  AWADDR,           // AXI write address
	input  wire logic        AWVALID,          // AXI write address valid
	output logic             AWREADY,          // AXI write address ready
	input  wire logic [31:0] WDATA,            // AXI write data
	input  wire logic [3:0]  WSTRB,            // AXI byte strobes
	input  wire logic        WVALID,           // AXI write data valid
	output logic             WREADY,           // AXI write data ready
	output logic [1:0]       BRESP,            // AXI write response
	output logic             BVALID,           // AXI write response valid
	input  wire logic        BREADY,           // AXI write response ready
	input  wire logic [7:0]  ARADDR,           // AXI read address
	input  wire logic        ARVALID,          // AXI read address valid
	output logic             ARREADY,          // AXI read address ready
	output logic [31:0]      RDATA,            // AXI read data
	output logic [1:0]       RRESP,            // AXI read response
	output logic             RVALID,           // AXI read data valid
	input  wire logic        RREADY,           // AXI read data ready
	output logic             IRQ,              // Level interrupt, high
	output logic [20:0]      FL_ADDR,          // Flash address
	output logic [7:0]       FL_DQ_O,          // Flash data out
	output logic             FL_DQ_OE,         // Flash data drive enable
	input  wire logic [7:0]  FL_DQ_I,          // Flash data in
	output logic             FL_CE_N,          // Flash chip enable
	output logic             FL_OE_N,          // Flash output enable
	output logic             FL_WE_N,          // Flash write enable
	input  wire logic        READY_BUSY_OUT_N  // Flash ready/busy level
);
	fwsr_main_s s_r, s_nxt;
	logic       cyc_done;
	logic [7:0] cyc_rd;
	logic       wr_fire;
	logic       rd_fire;

	fwsr_cyc fwsr_cyc_inst (
		.clk     (CLK),
		.rst     (RST),
		.go      (s_r.go),
		.we      (s_r.we),
		.addr    (s_r.addr),
		.wdata   (s_r.wd),
		.done    (cyc_done),
		.rdata   (cyc_rd),
		.fl_addr (FL_ADDR),
		.dq_o    (FL_DQ_O),
		.dq_oe   (FL_DQ_OE),
		.dq_i    (FL_DQ_I),
		.ce_n    (FL_CE_N),
		.oe_n    (FL_OE_N),
		.we_n    (FL_WE_N)
	);

	assign wr_fire = AWVALID && WVALID && !s_r.bvalid;
	assign rd_fire = ARVALID && !s_r.rvalid;
	assign AWREADY = wr_fire;
	assign WREADY = wr_fire;
	assign ARREADY = !s_r.rvalid;
	assign BVALID = s_r.bvalid;
	assign BRESP = s_r.bresp;
	assign RVALID = s_r.rvalid;
	assign RRESP = s_r.rresp;
	assign RDATA = s_r.rdata;
	assign IRQ = |(s_r.irq_stat & s_r.irq_mask);

	// ==========================================================
	// Sequencer, register file and bus slave
	always_comb begin
		logic [2:0] irq_set;
		logic [2:0] irq_clr;
		irq_set = 3'h0;
		irq_clr = 3'h0;
		s_nxt = s_r;
		s_nxt.go = 1'b0;

		// Flash cycle issue: one per state (one per step in S_ER_W), then wait for its end
		if (s_r.st != S_IDLE && s_r.st != S_FIN && !s_r.pend && !s_r.go) begin
			s_nxt.go = 1'b1;
			s_nxt.pend = 1'b1;
			s_nxt.we = 1'b0;
			s_nxt.addr = s_r.sector;
			s_nxt.wd = 8'h00;
			case (s_r.st)
				S_ER_W: begin
					s_nxt.we = 1'b1;
					case (s_r.step)
						3'h0, 3'h3: begin s_nxt.addr = UNLK_A1; s_nxt.wd = UNLK_D1; end
						3'h1, 3'h4: begin s_nxt.addr = UNLK_A2; s_nxt.wd = UNLK_D2; end
						3'h2: begin s_nxt.addr = UNLK_A1; s_nxt.wd = ERS_SETUP; end
						default: s_nxt.wd = SEC_ERASE;
					endcase
				end
				S_ADD_W: begin
					s_nxt.we = 1'b1;
					s_nxt.wd = SEC_ERASE;
				end
				S_RST_W: begin
					s_nxt.we = 1'b1;
					s_nxt.wd = FL_RESET;
				end
				default: s_nxt.we = 1'b0;
			endcase
		end

		if (cyc_done) begin
			s_nxt.pend = 1'b0;
			s_nxt.last = cyc_rd;
			case (s_r.st)
				S_ER_W: begin
					if (s_r.step == ERS_LAST) s_nxt.st = S_ACC_R1;
					s_nxt.step = s_r.step + 3'h1;
				end
				S_ACC_R1: begin
					s_nxt.first = cyc_rd;
					s_nxt.st = S_ACC_R2;
				end
				S_ACC_R2: begin
					// Toggling proves the sequence was taken
					s_nxt.accepted = cyc_rd[TOGGLE_ONE_POS] != s_r.first[TOGGLE_ONE_POS];
					s_nxt.rejected = !s_nxt.accepted;
					s_nxt.st = s_nxt.accepted ? S_TMR_R : S_FIN;
				end
				S_TMR_R: begin
					s_nxt.timer_hi = cyc_rd[TIMER_POS];
					s_nxt.st = S_FIN;
				end
				S_ADD_PRE: begin
					s_nxt.timer_hi = cyc_rd[TIMER_POS];
					// Erase already started: the device would drop the command
					s_nxt.rejected = cyc_rd[TIMER_POS];
					s_nxt.st = cyc_rd[TIMER_POS] ? S_FIN : S_ADD_W;
				end
				S_ADD_W: s_nxt.st = S_ADD_POST;
				S_ADD_POST: begin
					s_nxt.timer_hi = cyc_rd[TIMER_POS];
					s_nxt.rejected = cyc_rd[TIMER_POS];
					s_nxt.accepted = !cyc_rd[TIMER_POS];
					s_nxt.st = S_FIN;
				end
				S_POLL_R1: begin
					s_nxt.first = cyc_rd;
					s_nxt.st = S_POLL_R2;
				end
				S_POLL_R2: begin
					s_nxt.first = cyc_rd;
					if (cyc_rd[TOGGLE_ONE_POS] == s_r.first[TOGGLE_ONE_POS]) begin
						s_nxt.st = S_FIN;
					end else if (cyc_rd[FAIL_POS]) begin
						// Toggle may have stopped just as the fail bit rose
						s_nxt.st = S_POLL_R3;
					end else begin
						s_nxt.running = 1'b1;
						s_nxt.st = S_FIN;
					end
				end
				S_POLL_R3: begin
					if (cyc_rd[TOGGLE_ONE_POS] == s_r.first[TOGGLE_ONE_POS]) begin
						s_nxt.st = S_FIN;
					end else begin
						s_nxt.fail = 1'b1;
						s_nxt.st = S_RST_W;
					end
				end
				default: s_nxt.st = S_FIN;
			endcase
		end

		if (s_r.st == S_FIN) begin
			irq_set[IRQ_DONE] = 1'b1;
			irq_set[IRQ_REJ] = s_r.rejected;
			irq_set[IRQ_FAIL] = s_r.fail;
			s_nxt.st = S_IDLE;
		end

		// Register writes
		if (s_r.bvalid && BREADY) s_nxt.bvalid = 1'b0;
		if (wr_fire) begin
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = RESP_OKAY;
			case (AWADDR)
				REG_CTRL: begin
					if (WSTRB[0] && s_r.st == S_IDLE && WDATA[1:0] != 2'h0) begin
						s_nxt.step = 3'h0;
						s_nxt.pend = 1'b0;
						s_nxt.accepted = 1'b0;
						s_nxt.rejected = 1'b0;
						s_nxt.fail = 1'b0;
						s_nxt.running = 1'b0;
						case (WDATA[1:0])
							CMD_ERASE: s_nxt.st = S_ER_W;
							CMD_ADD: s_nxt.st = S_ADD_PRE;
							default: s_nxt.st = S_POLL_R1;
						endcase
					end
				end
				REG_SECTOR: begin
					for (int i = 0; i < 3; i++) begin
						if (WSTRB[i] && s_r.st == S_IDLE) begin
							if (i == 2) s_nxt.sector[20:16] = WDATA[20:16];
							else s_nxt.sector[i*8 +: 8] = WDATA[i*8 +: 8];
						end
					end
				end
				REG_STATUS: s_nxt.bresp = RESP_OKAY;
				REG_IRQ_STAT: if (WSTRB[0]) irq_clr = WDATA[2:0];
				REG_IRQ_MASK: if (WSTRB[0]) s_nxt.irq_mask = WDATA[2:0];
				default: s_nxt.bresp = RESP_SLVERR;
			endcase
		end
		// Set wins over a same-cycle clear
		s_nxt.irq_stat = (s_r.irq_stat & ~irq_clr) | irq_set;

		// Register reads
		if (s_r.rvalid && RREADY) s_nxt.rvalid = 1'b0;
		if (rd_fire) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = RESP_OKAY;
			s_nxt.rdata = 32'h00000000;
			case (ARADDR)
				REG_CTRL: s_nxt.rdata = 32'h00000000;
				REG_SECTOR: s_nxt.rdata = {11'h000, s_r.sector};
				REG_STATUS: s_nxt.rdata = {16'h0000, s_r.last, READY_BUSY_OUT_N,
					s_r.running, 1'b0, s_r.fail, s_r.rejected, s_r.timer_hi,
					s_r.accepted, s_r.st != S_IDLE};
				REG_IRQ_STAT: s_nxt.rdata = {29'h00000000, s_r.irq_stat};
				REG_IRQ_MASK: s_nxt.rdata = {29'h00000000, s_r.irq_mask};
				default: s_nxt.rresp = RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) s_r <= '0;
		else s_r <= s_nxt;
	end

	// ==========================================================
	// Checks
	property p_timer_after_accept;
		@(posedge CLK) disable iff (RST)
		(s_r.st == S_TMR_R) |-> s_r.accepted && $past(s_r.st == S_ACC_R2 || s_r.st == S_TMR_R);
	endproperty
	a_timer_after_accept: assert property (p_timer_after_accept) else $error("timer read before acceptance");

	property p_pre_check;
		@(posedge CLK) disable iff (RST)
		(s_r.st == S_ADD_W && $past(s_r.st) != S_ADD_W) |-> $past(s_r.st) == S_ADD_PRE && !s_r.timer_hi;
	endproperty
	a_pre_check: assert property (p_pre_check) else $error("add sector without prior timer check");

	property p_post_check;
		@(posedge CLK) disable iff (RST)
		(s_r.st == S_ADD_W && cyc_done) |=> s_r.st == S_ADD_POST ##[1:40] (s_r.st == S_FIN);
	endproperty
	a_post_check: assert property (p_post_check) else $error("no timer check after add sector");

	property p_valid_addr;
		@(posedge CLK) disable iff (RST)
		(s_r.go && !s_r.we) |-> s_r.addr == s_r.sector;
	endproperty
	a_valid_addr: assert property (p_valid_addr) else $error("status read at foreign address");

	c_erase_ok: cover property (@(posedge CLK) disable iff (RST)
		s_r.st == S_TMR_R && cyc_done);
	c_add_rej: cover property (@(posedge CLK) disable iff (RST)
		s_r.st == S_ADD_POST && cyc_done && cyc_rd[TIMER_POS]);
	c_fail: cover property (@(posedge CLK) disable iff (RST)
		s_r.st == S_RST_W);
endmodule

// *** fwsr_flash_model.sv ***
// Behavioural flash device: erase sequencing, sector erase timer and status byte
`timescale 1ns/1ps
module fwsr_flash_model import fwsr_pkg::*; #(
	parameter int TMO_CYC = 5000, // Acceptance time-out, 50 us at 100 MHz
	parameter int ERS_CYC = 3000  // Erase length, kept short for run time
) (
	input  wire logic        clk,      // Bench clock
	input  wire logic        ce_n,     // Chip enable
	input  wire logic        oe_n,     // Output enable
	input  wire logic        we_n,     // Write enable
	input  wire logic [20:0] addr,     // Address
	input  wire logic [7:0]  wd,       // Write data
	input  wire logic        fail_inj, // Erase never finishes
	output logic      [7:0]  dq,       // Data bus from device
	output logic             rb_low    // Ready/busy pull-down
);
	// ==========================================================
	// State: mode 0 read, 1 timer running, 2 erasing
	logic [1:0]  mode = 2'h0;
	logic [2:0]  step = 3'h0;
	logic [31:0] sel  = 32'h0;
	int          cnt  = 0;
	logic        t1   = 1'b0;
	logic        t2   = 1'b0;
	logic        pce  = 1'b1;
	logic        poe  = 1'b1;
	logic        pwe  = 1'b1;
	logic [7:0]  last = 8'h00;
	logic [7:0]  stat;
	logic [20:0] sa [5] = '{UNLK_A1, UNLK_A2, UNLK_A1, UNLK_A1, UNLK_A2};
	logic [7:0]  sd [5] = '{UNLK_D1, UNLK_D2, ERS_SETUP, UNLK_D1, UNLK_D2};
	wire         in_sel = sel[addr[20:16]];
	wire         drv    = !ce_n && !oe_n;

	// ==========================================================
	// Status byte and pins
	assign stat = (mode == 2'h0) ? 8'hFF : {1'b0, t1, fail_inj && mode == 2'h2, 1'b0,
		mode == 2'h2, in_sel && t2, 2'h0};
	// Released bus shows the inverse of the last byte, never a stale copy
	assign dq = drv ? stat : ~last;
	assign rb_low = (mode != 2'h0);

	// ==========================================================
	// Sequencing
	always @(posedge clk) begin
		pce <= ce_n;
		poe <= oe_n;
		pwe <= we_n;
		if (drv) last <= stat;
		if (drv && poe && mode != 2'h0) begin
			t1 <= !t1;
			if (in_sel) t2 <= !t2;
		end
		if (mode != 2'h0 && !(mode == 2'h2 && fail_inj)) cnt <= cnt + 1;
		if (mode == 2'h1 && cnt >= TMO_CYC) begin
			mode <= 2'h2;
			cnt <= 0;
		end
		if (mode == 2'h2 && !fail_inj && cnt >= ERS_CYC) begin
			mode <= 2'h0;
			sel <= 32'h0;
		end
		// Erasing ignores every command; a failed erase takes reset only
		if (!pwe && we_n && !pce) begin
			if (wd == FL_RESET && (mode == 2'h0 || fail_inj)) begin
				mode <= 2'h0;
				step <= 3'h0;
				sel <= 32'h0;
			end else if (mode == 2'h1 && wd == SEC_ERASE) begin
				sel[addr[20:16]] <= 1'b1;
				cnt <= 0;
			end else if (mode == 2'h0 && step < ERS_LAST) begin
				step <= (addr == sa[step] && wd == sd[step]) ? step + 3'h1 : 3'h0;
			end else if (mode == 2'h0) begin
				step <= 3'h0;
				cnt <= 0;
				if (wd == SEC_ERASE) mode <= 2'h1;
				if (wd == SEC_ERASE) sel[addr[20:16]] <= 1'b1;
				if (wd == 8'h10 && addr == UNLK_A1) mode <= 2'h2;
				if (wd == 8'h10 && addr == UNLK_A1) sel <= 32'hFFFFFFFF;
			end
		end
	end
endmodule

// *** tb_top.sv ***
// Self-checking bench: AXI4-Lite orders for erase, add-sector and status polling
`timescale 1ns/1ps
module tb_top import fwsr_pkg::*;;
	logic        CLK, RST, AWVALID, WVALID, BREADY, ARVALID, RREADY, AWREADY, WREADY;
	logic        BVALID, ARREADY, RVALID, IRQ, FL_DQ_OE, FL_CE_N, FL_OE_N, FL_WE_N;
	logic        READY_BUSY_OUT_N, rb_low, fail_inj;
	logic [7:0]  AWADDR, ARADDR, FL_DQ_O, FL_DQ_I, m_dq;
	logic [31:0] WDATA, RDATA, d;
	logic [3:0]  WSTRB;
	logic [1:0]  BRESP, RRESP, r;
	logic [20:0] FL_ADDR;
	int          fails, total_checks, cycles;

	fwsr_top fwsr_top_inst (.CLK(CLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID),
		.AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
		.BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
		.ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
		.IRQ(IRQ), .FL_ADDR(FL_ADDR), .FL_DQ_O(FL_DQ_O), .FL_DQ_OE(FL_DQ_OE),
		.FL_DQ_I(FL_DQ_I), .FL_CE_N(FL_CE_N), .FL_OE_N(FL_OE_N), .FL_WE_N(FL_WE_N),
		.READY_BUSY_OUT_N(READY_BUSY_OUT_N));
	fwsr_flash_model fwsr_flash_model_inst (.clk(CLK), .ce_n(FL_CE_N), .oe_n(FL_OE_N),
		.we_n(FL_WE_N), .addr(FL_ADDR), .wd(FL_DQ_O), .fail_inj(fail_inj), .dq(m_dq),
		.rb_low(rb_low));
	assign FL_DQ_I = FL_DQ_OE ? FL_DQ_O : m_dq;
	// Open-drain line with a pull-up
	assign READY_BUSY_OUT_N = rb_low ? 1'b0 : 1'b1;

	// ==========================================================
	// Clock, watchdog, report
	initial begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end
	initial begin
		forever begin
			@(posedge CLK);
			cycles++;
			if (cycles > 40000) begin
				fails++;
				final_report();
			end
		end
	end
	task automatic final_report();
		$display("Checks %0d, mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// ==========================================================
	// AXI4-Lite master tasks, entered just after a rising edge
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		AWADDR <= a;
		WDATA <= v;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		while (!(aw && w)) begin
			@(posedge CLK);
			if (AWREADY) aw = 1'b1;
			if (AWREADY) AWVALID <= 1'b0;
			if (WREADY) w = 1'b1;
			if (WREADY) WVALID <= 1'b0;
		end
		do @(posedge CLK); while (!BVALID);
		rs = BRESP;
		BREADY <= 1'b0;
		@(posedge CLK);
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		do @(posedge CLK); while (!ARREADY);
		ARVALID <= 1'b0;
		do @(posedge CLK); while (!RVALID);
		v = RDATA;
		rs = RRESP;
		RREADY <= 1'b0;
		@(posedge CLK);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic [1:0] rs;
		axi_wr(a, v, rs);
		chk(32'(rs), 32'(RESP_OKAY));
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] v;
		logic [1:0]  rs;
		axi_rd(a, v, rs);
		chk(v & m, e);
	endtask
	// Issue an order and wait for the busy flag to drop
	task automatic run_op(input logic [1:0] c);
		logic [31:0] v;
		logic [1:0]  rs;
		wr(REG_CTRL, {30'h0, c});
		v = 32'h1;
		while (v[0]) axi_rd(REG_STATUS, v, rs);
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		RST <= 1'b1;
		{AWVALID, WVALID, BREADY, ARVALID, RREADY, fail_inj} <= 6'h00;
		{AWADDR, ARADDR, WDATA} <= 48'h0;
		WSTRB <= 4'hF;
		repeat (2) @(posedge CLK);
		RST <= 1'b0;
		@(posedge CLK);
		rd_chk(REG_IRQ_MASK, 32'hFFFFFFFF, 32'h0);
		rd_chk(REG_STATUS, 32'h81, 32'h80);
		axi_wr(8'h20, 32'h1, r);
		chk(32'(r), 32'(RESP_SLVERR));
		axi_rd(8'h20, d, r);
		chk(d, 32'h0);
		chk(32'(r), 32'(RESP_SLVERR));
		wr(REG_IRQ_MASK, 32'h7);
		rd_chk(REG_IRQ_MASK, 32'h7, 32'h7);
		wr(REG_SECTOR, 32'h030000);
		rd_chk(REG_SECTOR, 32'hFFFFFFFF, 32'h030000);
		rd_chk(REG_CTRL, 32'hFFFFFFFF, 32'h0);
		run_op(CMD_ERASE);
		rd_chk(REG_STATUS, 32'h088E, 32'h0002);
		chk(32'(IRQ), 32'h1);
		wr(REG_IRQ_STAT, 32'h7);
		chk(32'(IRQ), 32'h0);
		// Second add lands past the first deadline: only a restart keeps it open
		for (int i = 0; i < 2; i++) begin
			wr(REG_SECTOR, 32'h050000 + 32'(i) * 32'h10000);
			repeat (3000) @(posedge CLK);
			run_op(CMD_ADD);
			rd_chk(REG_STATUS, 32'h8C, 32'h0);
		end
		repeat (5500) @(posedge CLK);
		run_op(CMD_ADD);
		rd_chk(REG_STATUS, 32'h8C, 32'h0C);
		rd_chk(REG_IRQ_STAT, 32'h2, 32'h2);
		run_op(CMD_POLL);
		rd_chk(REG_STATUS, 32'h88D0, 32'h0840);
		repeat (3500) @(posedge CLK);
		run_op(CMD_POLL);
		rd_chk(REG_STATUS, 32'hD0, 32'h80);
		fail_inj <= 1'b1;
		wr(REG_IRQ_STAT, 32'h7);
		run_op(CMD_ERASE);
		repeat (5200) @(posedge CLK);
		run_op(CMD_POLL);
		rd_chk(REG_STATUS, 32'h90, 32'h90);
		fail_inj <= 1'b0;
		rd_chk(REG_IRQ_STAT, 32'h4, 32'h4);
		wr(REG_IRQ_MASK, 32'h0);
		chk(32'(IRQ), 32'h0);
		wr(REG_IRQ_MASK, 32'h4);
		chk(32'(IRQ), 32'h1);
		wr(REG_IRQ_STAT, 32'h4);
		chk(32'(IRQ), 32'h0);
		final_report();
	end
endmodule
